// [hdl/lane_tap_pkg.sv]
// Purpose: Shared constants, types and helpers for the lane tap delay control
// Assumes: 32-bit APB data, six lane slices, 9-bit tap fields
// Notes: Offsets are byte addresses on the APB
package lane_tap_pkg;

    localparam int NUM_SLICES = 6;
    localparam logic [8:0] TAP_MAX = 9'h1ff;
    localparam logic [9:0] CHAIN_MAX = 10'h3ff;
    localparam logic [8:0] ALIGN_MAX = 9'h12c;
    localparam logic [15:0] TAP_PS_DEFAULT = 16'h0005;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_TRISTATE = 8'h08;
    localparam logic [7:0] OFF_REMOTE = 8'h0c;
    localparam logic [7:0] OFF_UI_TAPS = 8'h10;
    localparam logic [7:0] OFF_INIT_BASE = 8'h20;
    localparam logic [7:0] OFF_ALIGN_BASE = 8'h40;

    // Field positions
    localparam int CTRL_CAL_EN = 6;
    localparam int CTRL_TRI_SERIAL = 7;
    localparam int CTRL_GO = 8;
    localparam int REM_LINE = 12;

    // Reset values
    localparam logic [9:0] UI_TAPS_RST = 10'h100;
    localparam logic [8:0] TRI_RST = 9'h000;
    localparam logic [15:0] INIT_PS_RST = 16'h0000;

    // Init sequence, Gray coded along the usual path
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CAL = 2'b01,
        PH_INIT = 2'b11,
        PH_READY = 2'b10
    } phase_e;

    // Saturate an 11-bit sum into a 9-bit tap count
    function automatic logic [8:0] sat_tap(input logic [10:0] v);
        return (v > {2'b00, TAP_MAX}) ? TAP_MAX : v[8:0];
    endfunction

    // Time to taps, clamped to the single or chained range
    function automatic logic [9:0] ps_to_taps(input logic [15:0] ps, input logic [15:0] ps_per_tap,
                                              input logic chained);
        logic [15:0] t;
        t = ps / ps_per_tap;
        if (chained) begin
            return (t > {6'h00, CHAIN_MAX}) ? CHAIN_MAX : t[9:0];
        end
        return (t > {7'h00, TAP_MAX}) ? {1'b0, TAP_MAX} : t[9:0];
    endfunction

endpackage

// [hdl/tap_line.sv]
// Purpose: One programmable delay line: tap counter and applied value
// Assumes: Operation strobes come from logic on pclk
// Notes: Applied value trails the count by one edge
`timescale 1ns/10ps
module tap_line (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Operations
    input wire logic init_go,
    input wire logic [8:0] init_value,
    input wire logic load,
    input wire logic step,
    input wire logic up,
    input wire logic [8:0] value_in,
    // State
    output logic [8:0] count,
    output logic [8:0] applied
);

    typedef struct packed {
        logic [8:0] count;
        logic [8:0] applied;
    } tap_line_s;

    tap_line_s st;
    tap_line_s next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Operation decode; unsupported 110 holds
    always_comb begin
        next_st = st;
        next_st.applied = st.count;
        if (init_go) begin
            next_st.count = init_value;
        end else if (load && step && up) begin
            next_st.count = lane_tap_pkg::sat_tap({2'b00, st.count} + {2'b00, value_in});
        end else if (load && !step) begin
            next_st.count = value_in;
        end else if (step && !load) begin
            if (up) begin
                next_st.count = (st.count == lane_tap_pkg::TAP_MAX) ? st.count : st.count + 9'h001;
            end else begin
                next_st.count = (st.count == 9'h000) ? st.count : st.count - 9'h001;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign applied = st.applied;

endmodule // tap_line

// [hdl/align_offset_keeper.sv]
// Purpose: Captures the per-slice alignment offset once after reset
// Assumes: Measurement is steady when capture pulses
// Notes: Later captures are ignored until reset
`timescale 1ns/10ps
module align_offset_keeper (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Capture control
    input wire logic capture,
    input wire logic cal_enable,
    input wire logic [53:0] measure,
    // Held offsets
    output logic [53:0] offset,
    output logic valid
);

    typedef struct packed {
        logic [53:0] offset;
        logic valid;
    } align_s;

    align_s st;
    align_s next_st;

    ////////////////////////////////////////////////////////////////////////////
    // One capture per reset, clamped at the ceiling
    always_comb begin
        next_st = st;
        if (capture && !st.valid) begin
            next_st.valid = 1'b1;
            for (int s = 0; s < lane_tap_pkg::NUM_SLICES; s++) begin
                if (!cal_enable) begin
                    next_st.offset[s*9 +: 9] = 9'h000;
                end else if (measure[s*9 +: 9] > lane_tap_pkg::ALIGN_MAX) begin
                    next_st.offset[s*9 +: 9] = lane_tap_pkg::ALIGN_MAX;
                end else begin
                    next_st.offset[s*9 +: 9] = measure[s*9 +: 9];
                end
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign offset = st.offset;
    assign valid = st.valid;

endmodule // align_offset_keeper

// [hdl/lane_tap_delay_control.sv]
// Purpose: Tap delay control for six lane slices, fabric and APB update paths
// Assumes: Fabric ports, calibration inputs and APB all on pclk
// Notes: Registers reached over APB; one wait state on every access
// Contract
// - Chaining joins both lines into one receive delay.
// - Picosecond initial delay seeds both lines as taps; max doubles when chained.
// - New value on tap_value_out first, applied one clock later.
// - APB update one clock later; needs drift enables, load, no step.
// - Fabric ports change only input and output lines.
// - Serial drive source: tristate delay from its APB register.
// - Output delays of 1.5 UI or more lose bit alignment.
// - Line 0 with load pattern 10x loads input line from slice field.
// - Only a changed line may report inaccurately while settling.
// - Zero initial delay: input readback shows the offset.
// - Offset computed once per slice, kept until reset.
// - Offset on input lines only; zero without calibration.
// - Input line readback includes the alignment offset.
// - Drift compensation covers taps above offset up to initial mark.
// - Offset may reach 300 taps, reducing input line range.
// - Output readback shows only the programmed initial delay.
// - Step, load, add or hold decoded per selected line.
// - Slice n uses bits 9n+8 down to 9n of the buses, and 10n+9 down to 10n of rx_delay_taps.
// - Each line spans 0 to 511 taps.
// - Chained slice has its transmit path disabled.
`timescale 1ns/10ps
module lane_tap_delay_control #(
    parameter logic [15:0] TAP_PS = lane_tap_pkg::TAP_PS_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fabric delay control
    input wire logic [5:0] load_strobe,
    input wire logic [5:0] step_enable,
    input wire logic [5:0] step_up,
    input wire logic [5:0] line_select,
    input wire logic [53:0] tap_value_in,
    input wire logic rx_drift_comp_enable,
    input wire logic tx_drift_comp_enable,
    output logic [53:0] tap_value_out,
    output logic delay_ready_flag,
    // Self-calibration
    input wire logic cal_done,
    input wire logic [53:0] align_measure,
    // Datapath settings
    output logic [59:0] rx_delay_taps,
    output logic [53:0] tx_delay_taps,
    output logic [5:0] tx_path_enable,
    output logic [8:0] tristate_delay_taps,
    output logic [53:0] drift_comp_taps
);

    typedef struct packed {
        lane_tap_pkg::phase_e phase;
        logic ready;
        logic [5:0] chain;
        logic cal_en;
        logic tri_serial;
        logic [8:0] tri_delay;
        logic [9:0] ui_taps;
        logic [5:0][15:0] init_ps;
        logic rem_pend;
        logic [2:0] rem_slice;
        logic rem_line;
        logic [8:0] rem_value;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [53:0] tap_out;
        logic [59:0] rx_taps;
        logic [53:0] tx_taps;
        logic [5:0] tx_en;
        logic [8:0] tri_taps;
        logic [53:0] comp_taps;
        logic [5:0] align_warn;
    } ctrl_s;

    ctrl_s st;
    ctrl_s next_st;

    // Per-line wiring, index 2*s for input, 2*s+1 for output
    logic [11:0] op_load;
    logic [11:0] op_step;
    logic [11:0] op_up;
    logic [11:0][8:0] op_value;
    logic [11:0][8:0] init_value;
    logic [11:0][8:0] line_count;
    logic [11:0][8:0] line_applied;
    logic [53:0] align_off;
    logic align_valid;
    logic capture;
    logic init_go;
    logic apb_setup;
    logic apb_done;
    logic [8:0] mark;
    logic [9:0] init_taps;
    logic [8:0] floor_taps;
    logic [8:0] low_taps;

    ////////////////////////////////////////////////////////////////////////////
    // Offset capture and the delay lines
    align_offset_keeper u_align (
        .pclk(pclk),
        .presetn(presetn),
        .capture(capture),
        .cal_enable(st.phase == lane_tap_pkg::PH_CAL),
        .measure(align_measure),
        .offset(align_off),
        .valid(align_valid)
    );

    for (genvar i = 0; i < 12; i++) begin : g_line
        tap_line u_line (
            .pclk(pclk),
            .presetn(presetn),
            .init_go(init_go),
            .init_value(init_value[i]),
            .load(op_load[i]),
            .step(op_step[i]),
            .up(op_up[i]),
            .value_in(op_value[i]),
            .count(line_count[i]),
            .applied(line_applied[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration capture and one init pulse per reset
    assign capture = (st.phase == lane_tap_pkg::PH_CAL && cal_done) ||
                     (st.phase == lane_tap_pkg::PH_IDLE && apb_done && pwrite && paddr == lane_tap_pkg::OFF_CTRL &&
                      pwdata[lane_tap_pkg::CTRL_GO] && !pwdata[lane_tap_pkg::CTRL_CAL_EN]);
    assign init_go = (st.phase == lane_tap_pkg::PH_INIT);

    // Initial seeds; offset only on the input line, halves when chained
    always_comb begin
        for (int s = 0; s < lane_tap_pkg::NUM_SLICES; s++) begin
            init_taps = lane_tap_pkg::ps_to_taps(st.init_ps[s], TAP_PS, st.chain[s]);
            if (st.chain[s]) begin
                init_value[2*s] = lane_tap_pkg::sat_tap({2'b00, init_taps[9:1]} + {2'b00, align_off[s*9 +: 9]});
                init_value[2*s+1] = init_taps[9:1] + {8'h00, init_taps[0]};
            end else begin
                init_value[2*s] = lane_tap_pkg::sat_tap({1'b0, init_taps} + {2'b00, align_off[s*9 +: 9]});
                init_value[2*s+1] = init_taps[8:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fabric and APB update decode; only input and output lines exist here
    always_comb begin
        op_load = '0;
        op_step = '0;
        op_up = '0;
        op_value = '0;
        for (int s = 0; s < lane_tap_pkg::NUM_SLICES; s++) begin
            for (int l = 0; l < 2; l++) begin
                if (st.ready && line_select[s] == l[0]) begin
                    op_load[2*s+l] = load_strobe[s];
                    op_step[2*s+l] = step_enable[s];
                    op_up[2*s+l] = step_up[s];
                    op_value[2*s+l] = tap_value_in[s*9 +: 9];
                end
            end
        end
        // Queued APB update one edge late; step_up has no say
        if (st.rem_pend && st.ready && rx_drift_comp_enable && tx_drift_comp_enable &&
            load_strobe[st.rem_slice] && !step_enable[st.rem_slice]) begin
            op_load[{st.rem_slice, st.rem_line}] = 1'b1;
            op_step[{st.rem_slice, st.rem_line}] = 1'b0;
            op_up[{st.rem_slice, st.rem_line}] = 1'b0;
            op_value[{st.rem_slice, st.rem_line}] = st.rem_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: setup seen, answer one edge later
    assign apb_setup = psel && penable && !st.pready;
    assign apb_done = psel && penable && st.pready;

    // Read mux and control state
    always_comb begin
        next_st = st;
        next_st.pready = apb_setup;
        next_st.pslverr = 1'b0;
        next_st.ready = (st.phase == lane_tap_pkg::PH_READY);
        next_st.rem_pend = 1'b0; // Dropped if conditions are not met
        if (apb_setup) begin
            next_st.prdata = 32'h0000_0000;
            unique case (paddr)
                lane_tap_pkg::OFF_CTRL: begin
                    next_st.prdata = {23'h000000, 1'b0, st.tri_serial, st.cal_en, st.chain};
                end
                lane_tap_pkg::OFF_STATUS: begin
                    next_st.prdata = {24'h000000, align_valid, st.align_warn, st.ready};
                end
                lane_tap_pkg::OFF_TRISTATE: begin
                    next_st.prdata = {23'h000000, st.tri_delay};
                end
                lane_tap_pkg::OFF_REMOTE: begin
                    next_st.prdata = {19'h00000, st.rem_line, st.rem_slice, st.rem_value};
                end
                lane_tap_pkg::OFF_UI_TAPS: begin
                    next_st.prdata = {22'h000000, st.ui_taps};
                end
                default: begin
                    if (paddr >= lane_tap_pkg::OFF_INIT_BASE && paddr < lane_tap_pkg::OFF_INIT_BASE + 8'h18 &&
                        paddr[1:0] == 2'b00) begin
                        next_st.prdata = {16'h0000, st.init_ps[paddr[4:2]]};
                    end else if (paddr >= lane_tap_pkg::OFF_ALIGN_BASE &&
                                 paddr < lane_tap_pkg::OFF_ALIGN_BASE + 8'h18 && paddr[1:0] == 2'b00) begin
                        next_st.prdata = {23'h000000, align_off[paddr[4:2]*9 +: 9]};
                    end else begin
                        next_st.pslverr = 1'b1; // Unmapped
                    end
                end
            endcase
        end
        // Writes take effect at the completing edge
        if (apb_done && pwrite) begin
            unique case (paddr)
                lane_tap_pkg::OFF_CTRL: begin
                    next_st.chain = pwdata[5:0];
                    next_st.cal_en = pwdata[lane_tap_pkg::CTRL_CAL_EN];
                    next_st.tri_serial = pwdata[lane_tap_pkg::CTRL_TRI_SERIAL];
                    if (st.phase == lane_tap_pkg::PH_IDLE && pwdata[lane_tap_pkg::CTRL_GO]) begin
                        next_st.phase = pwdata[lane_tap_pkg::CTRL_CAL_EN] ? lane_tap_pkg::PH_CAL
                                                                          : lane_tap_pkg::PH_INIT;
                    end
                end
                lane_tap_pkg::OFF_TRISTATE: begin
                    next_st.tri_delay = pwdata[8:0];
                end
                lane_tap_pkg::OFF_REMOTE: begin
                    if (pwdata[11:9] < 3'h6) begin
                        next_st.rem_pend = 1'b1; // New write wins over the drop
                        next_st.rem_value = pwdata[8:0];
                        next_st.rem_slice = pwdata[11:9];
                        next_st.rem_line = pwdata[lane_tap_pkg::REM_LINE];
                    end
                end
                lane_tap_pkg::OFF_UI_TAPS: begin
                    next_st.ui_taps = pwdata[9:0];
                end
                default: begin
                    if (paddr >= lane_tap_pkg::OFF_INIT_BASE && paddr < lane_tap_pkg::OFF_INIT_BASE + 8'h18 &&
                        paddr[1:0] == 2'b00) begin
                        next_st.init_ps[paddr[4:2]] = pwdata[15:0];
                    end
                end
            endcase
        end
        // Init sequence advance
        unique case (st.phase)
            lane_tap_pkg::PH_IDLE: begin
            end
            lane_tap_pkg::PH_CAL: begin
                if (cal_done) begin
                    next_st.phase = lane_tap_pkg::PH_INIT;
                end
            end
            lane_tap_pkg::PH_INIT: begin
                next_st.phase = lane_tap_pkg::PH_READY;
            end
            lane_tap_pkg::PH_READY: begin
            end
        endcase
        // Readback, datapath and compensation window per slice
        for (int s = 0; s < lane_tap_pkg::NUM_SLICES; s++) begin
            next_st.tap_out[s*9 +: 9] = line_select[s] ? line_count[2*s+1] : line_count[2*s];
            next_st.rx_taps[s*10 +: 10] = st.chain[s] ? {1'b0, line_applied[2*s]} + {1'b0, line_applied[2*s+1]}
                                                      : {1'b0, line_applied[2*s]};
            next_st.tx_taps[s*9 +: 9] = st.chain[s] ? 9'h000 : line_applied[2*s+1];
            next_st.tx_en[s] = !st.chain[s];
            next_st.align_warn[s] = {2'b00, line_count[2*s+1], 1'b0} >= {1'b0, st.ui_taps, 1'b0} +
                                    {2'b00, st.ui_taps};
            mark = init_value[2*s+1]; // Programmed seed, offset excluded
            floor_taps = align_off[s*9 +: 9];
            low_taps = (line_count[2*s] < mark) ? line_count[2*s] : mark;
            next_st.comp_taps[s*9 +: 9] = (rx_drift_comp_enable && low_taps > floor_taps) ?
                                          low_taps - floor_taps : 9'h000;
        end
        next_st.tri_taps = st.tri_serial ? st.tri_delay : 9'h000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.phase <= lane_tap_pkg::PH_IDLE;
            st.ui_taps <= lane_tap_pkg::UI_TAPS_RST;
            st.tri_delay <= lane_tap_pkg::TRI_RST;
            st.tx_en <= 6'h3f;
            for (int s = 0; s < lane_tap_pkg::NUM_SLICES; s++) begin
                st.init_ps[s] <= lane_tap_pkg::INIT_PS_RST;
            end
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign tap_value_out = st.tap_out;
    assign delay_ready_flag = st.ready;
    assign rx_delay_taps = st.rx_taps;
    assign tx_delay_taps = st.tx_taps;
    assign tx_path_enable = st.tx_en;
    assign tristate_delay_taps = st.tri_taps;
    assign drift_comp_taps = st.comp_taps;

endmodule // lane_tap_delay_control

// [sim/lane_tap_delay_control_props.sv]
// Purpose: Port checks for lane tap delay control
// Assumes: One pclk domain
// Notes: Bound into every top instance
`timescale 1ns/10ps
module lane_tap_delay_control_props (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Delay side
    input wire logic [5:0] load_strobe,
    input wire logic [5:0] step_enable,
    input wire logic [5:0] line_select,
    input wire logic [53:0] tap_value_in,
    input wire logic rx_drift_comp_enable,
    input wire logic tx_drift_comp_enable,
    input wire logic [53:0] tap_value_out,
    input wire logic delay_ready_flag,
    input wire logic [59:0] rx_delay_taps,
    input wire logic [53:0] tx_delay_taps,
    input wire logic [5:0] tx_path_enable,
    input wire logic [53:0] drift_comp_taps
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // One-cycle answer, error only with it
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    chk_err_paired: assert property (pslverr |-> pready && $past(psel && penable)) else $error("stray pslverr");
    chk_chain_tx_off: assert property (
        !tx_path_enable[1] |-> tx_delay_taps[17:9] == 9'h000) else $error("tx taps on chained slice");
    // Applied value trails readback by one cycle
    chk_apply_lag: assert property (
        $changed(tap_value_out[8:0]) && !line_select[0] && $stable(line_select[0]) && tx_path_enable[0]
        |=> rx_delay_taps[9:0] == {1'b0, $past(tap_value_out[8:0])}) else $error("applied lag");
    chk_fabric_load: assert property (
        delay_ready_flag && load_strobe[2] && !step_enable[2] && !line_select[2]
        |-> ##[1:2] tap_value_out[26:18] == $past(tap_value_in[26:18])) else $error("fabric load");
    // Quiet slice keeps its readback
    chk_quiet_hold: assert property (
        (delay_ready_flag && !load_strobe[0] && !step_enable[0] && !line_select[0]) [*3]
        |=> $stable(tap_value_out[8:0])) else $error("quiet slice moved");
    // Remote path into slice 3 input line
    chk_remote_load: assert property (
        psel && penable && pready && pwrite && paddr == 8'h0c && pwdata[12:9] == 4'h3 && rx_drift_comp_enable
        && tx_drift_comp_enable && load_strobe[3] && !step_enable[3]
        |-> ##[2:4] tap_value_out[35:27] == pwdata[8:0]) else $error("remote load");
    chk_drift_off: assert property (
        !rx_drift_comp_enable [*2] |-> drift_comp_taps == 54'h0) else $error("drift taps while off");
endmodule // lane_tap_delay_control_props

bind lane_tap_delay_control lane_tap_delay_control_props chk (.*);

// [sim/fabric_ctrl_model.sv]
// Purpose: Fabric controller for the delay line ports
// Assumes: Bench launches requests through op
// Notes: Released data shows the inverse of the last value
`timescale 1ns/10ps
module fabric_ctrl_model (
    // Clock and status
    input wire logic pclk,
    input wire logic delay_ready_flag,
    // Delay control
    output logic [5:0] load_strobe,
    output logic [5:0] step_enable,
    output logic [5:0] step_up,
    output logic [5:0] line_select,
    output logic [53:0] tap_value_in
);
    initial begin
        {load_strobe, step_enable, step_up, line_select, tap_value_in} = '0;
    end
    ////////////////////////////////////////////////////////////
    // Request held n cycles, then a quiet window so the line never glitches
    task automatic op(input int s, input logic l, input logic [2:0] c, input logic [8:0] v, input int n);
        while (delay_ready_flag !== 1'b1) @(posedge pclk);
        @(posedge pclk);
        line_select[s] <= l;
        {load_strobe[s], step_enable[s], step_up[s]} <= c;
        tap_value_in[9*s+:9] <= v;
        repeat (n) @(posedge pclk);
        {load_strobe[s], step_enable[s], step_up[s]} <= 3'b000;
        repeat (2) @(posedge pclk);
        tap_value_in[9*s+:9] <= ~v;
    endtask
endmodule // fabric_ctrl_model

// [sim/lane_tap_delay_control_bench.sv]
// Purpose: Self-checking bench for lane tap delay control
// Assumes: 5 ps per tap, offset clamp at 300 taps
// Notes: Integer counts per line and slice predict each readback
`timescale 1ns/10ps
module lane_tap_delay_control_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_drift_comp_enable, tx_drift_comp_enable;
    logic cal_done, delay_ready_flag, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed = 32'h407b;
    logic [5:0] load_strobe, step_enable, step_up, line_select, tx_path_enable;
    logic [53:0] tap_value_in, tap_value_out, align_measure, tx_delay_taps, drift_comp_taps;
    logic [59:0] rx_delay_taps;
    logic [8:0] tristate_delay_taps;
    logic [2:0] codes [8] = '{3'b010, 3'b011, 3'b100, 3'b101, 3'b111, 3'b110, 3'b000, 3'b001};
    int failures = 0, tests_run = 0, cnt [2][6], v, s;
    lane_tap_delay_control dut (.*);
    fabric_ctrl_model fab (.*);
    ////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Predict, issue, compare
    task automatic fop(input int s, input int l, input logic [2:0] c, input int v);
        int n;
        n = cnt[l][s];
        case (c)
            3'b010: n = (n > 0) ? n - 1 : 0;
            3'b011: n = (n < 511) ? n + 1 : 511;
            3'b100, 3'b101: n = v;
            3'b111: n = (n + v > 511) ? 511 : n + v;
            default: ;
        endcase
        cnt[l][s] = n;
        fab.op(s, l[0], c, v[8:0], 1);
        repeat (3) @(posedge pclk);
        chk(32'(tap_value_out[9*s+:9]), n);
        if (s == 0 && l == 0) chk(32'(rx_delay_taps[9:0]), n);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, roughly eighteen times the expected run
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, cal_done, paddr, pwdata} = '0;
        {rx_drift_comp_enable, tx_drift_comp_enable} = 2'b11;
        align_measure = {27'h0, 9'h190, 9'h000, 9'h00a}; // Slice 2 beyond the clamp
        {cnt[0][0], cnt[1][0], cnt[0][2]} = {32'd110, 32'd100, 32'd300};
        repeat (12) @(posedge pclk);
        chk(32'(tx_path_enable), 32'h3f);
        presetn <= 1'b1;
        apb(1'b1, 8'h20, 32'd500);
        apb(1'b1, 8'h24, 32'd3000);
        apb(1'b1, 8'h08, 32'h2a);
        apb(1'b1, 8'h00, 32'h1c2); // Chain slice 1, calibrate, serial tristate, go
        cal_done <= 1'b1;
        for (int k = 0; k < 300 && delay_ready_flag !== 1'b1; k++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk(32'(rx_delay_taps[19:10]), 32'd600);
        chk(32'(tx_path_enable[1] | tx_delay_taps[17:9]), 0);
        chk(32'(drift_comp_taps[8:0]), 32'd90);
        chk(32'(tristate_delay_taps), 32'h2a);
        apb(1'b0, 8'h40, 0);
        chk(rd, 32'd10);
        apb(1'b0, 8'h48, 0);
        chk(rd, 32'd300);
        apb(1'b0, 8'hfc, 0);
        chk(32'(e), 1);
        fop(0, 1, 3'b000, 0);
        fop(0, 0, 3'b000, 0);
        fop(2, 0, 3'b000, 0);
        fop(1, 0, 3'b100, 296);
        fop(1, 1, 3'b100, 296);
        chk(32'(rx_delay_taps[19:10]), 32'd592);
        // Every code on both slices, jumps kept small
        for (int i = 0; i < 16; i++) begin
            s = (i / 8) * 2;
            v = xs() % 9;
            fop(s, 0, codes[i % 8], codes[i % 8][1] ? v : cnt[0][s] + v - 4);
        end
        while (cnt[0][2] < 511) fop(2, 0, 3'b111, 8);
        fop(2, 0, 3'b011, 0);
        while (cnt[0][0] > 0) fop(0, 0, 3'b100, (cnt[0][0] > 8) ? cnt[0][0] - 8 : 0);
        fop(0, 0, 3'b010, 0);
        // Remote load lands, then is dropped while stepping
        for (int k = 0; k < 2; k++) begin
            fork fab.op(3, 0, k ? 3'b110 : 3'b100, 9'h055, 14); join_none
            repeat (3) @(posedge pclk);
            apb(1'b1, 8'h0c, 32'h06aa);
            repeat (16) @(posedge pclk);
        end
        chk(32'(tap_value_out[35:27]), 32'h55);
        rx_drift_comp_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(drift_comp_taps[8:0]), 0);
        conclude();
    end
endmodule // lane_tap_delay_control_bench
